// ===== rtl/mcuic_top.sv
// Purpose: Interrupt flags, enables, vector request and wake-up for core
// Assumes: Clock is the instruction clock; pins are asynchronous
// Notes:   Vector fires in the cycle after the core reports taking it
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module mcuic_top #(
  parameter int PERIPH_W = 8
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  // Register port
  input  wire mcuic_pkg::mcuic_bus_s bus,
  output logic [7:0]                rdata,
  // Pins
  input  wire logic                 external_irq_pin,
  input  wire logic [3:0]           port_b_pins,
  // Core side
  input  wire logic [7:0]           eight_bit_timer,
  input  wire logic [PERIPH_W-1:0]  periph_events,
  input  wire mcuic_pkg::mcuic_core_s core,
  input  wire logic                 return_from_handler,
  input  wire logic                 in_sleep,
  output logic                      irq_request,
  output logic                      wake_up,
  output logic                      vector_load,
  output logic [12:0]               vector_pc,
  output logic                      push_valid,
  output logic [12:0]               push_addr,
  output logic                      irq_out
);
  //////////////////////////////////////////////////////////////////////////
  logic [1:0] pin_sync_q, pin_sync_d;
  logic [1:0] pin_hist_q, pin_hist_d;
  logic [3:0] pb_s1_q, pb_s2_q, pb_last_q;
  logic [3:0] pb_s1_d, pb_s2_d, pb_last_d;
  logic [7:0] tmr_last_q, tmr_last_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] pflg_q, pflg_d;
  logic [7:0] pena_q, pena_d;
  logic [7:0] opt_q, opt_d;
  logic [2:0] evst_q, evst_d;
  logic [2:0] evmk_q, evmk_d;
  logic [7:0] rdata_q, rdata_d;
  logic       req_q, req_d, wake_q, wake_d, vld_q, vld_d, push_q, push_d;
  logic       irq_q, irq_d;
  logic [12:0] vpc_q, vpc_d, padr_q, padr_d;
  logic       pin_edge, pb_chg, tmr_ovf, pend_core, pend_per, pend_any;
  logic [7:0] pev;

  function automatic logic wr_hit(input mcuic_pkg::mcuic_bus_s b,
                                  input logic [7:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  function automatic logic rd_hit(input mcuic_pkg::mcuic_bus_s b,
                                  input logic [7:0] a);
    rd_hit = b.rd && (b.addr == a);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Event detection: pins synchronised, pin edge taken across third and fourth stages
  always_comb begin
    pin_sync_d = {pin_sync_q[0], external_irq_pin};
    pin_hist_d = {pin_hist_q[0], pin_sync_q[1]};
    pb_s1_d    = port_b_pins;
    pb_s2_d    = pb_s1_q;
    pb_last_d  = pb_s2_q;
    tmr_last_d = eight_bit_timer;
    pin_edge = opt_q[mcuic_pkg::EDGE_SEL_BIT] ?
               (pin_hist_q[0] && !pin_hist_q[1]) :
               (!pin_hist_q[0] && pin_hist_q[1]);
    pb_chg   = (pb_s2_q != pb_last_q);
    tmr_ovf  = (tmr_last_q == mcuic_pkg::TIMER_MAX) &&
               (eight_bit_timer == 8'h00);
    pev = 8'h00;
    pev[PERIPH_W-1:0] = periph_events;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_q <= 2'h0;
      pin_hist_q <= 2'h0;
      pb_s1_q    <= 4'h0;
      pb_s2_q    <= 4'h0;
      pb_last_q  <= 4'h0;
      tmr_last_q <= 8'h00;
    end else begin
      pin_sync_q <= pin_sync_d;
      pin_hist_q <= pin_hist_d;
      pb_s1_q    <= pb_s1_d;
      pb_s2_q    <= pb_s2_d;
      pb_last_q  <= pb_last_d;
      tmr_last_q <= tmr_last_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers; software write first, hardware sets applied after
  always_comb begin
    ctrl_d = ctrl_q;
    pflg_d = pflg_q;
    pena_d = pena_q;
    opt_d  = opt_q;
    evmk_d = evmk_q;
    evst_d = evst_q;
    if (wr_hit(bus, mcuic_pkg::CORE_CTRL_ADDR)) begin
      ctrl_d = bus.wdata;
    end
    if (wr_hit(bus, mcuic_pkg::PERIPH_FLG_ADDR)) begin
      pflg_d = bus.wdata & mcuic_pkg::PERIPH_IMPL;
    end
    if (wr_hit(bus, mcuic_pkg::PERIPH_ENA_ADDR)) begin
      pena_d = bus.wdata & mcuic_pkg::PERIPH_IMPL;
    end
    if (wr_hit(bus, mcuic_pkg::OPTION_ADDR)) begin
      opt_d = bus.wdata;
    end
    if (wr_hit(bus, mcuic_pkg::EVT_MASK_ADDR)) begin
      evmk_d = bus.wdata[2:0];
    end
    if (core.take) begin
      ctrl_d[mcuic_pkg::GEN_BIT] = 1'b0;
    end else if (return_from_handler) begin
      ctrl_d[mcuic_pkg::GEN_BIT] = 1'b1;
    end
    if (pin_edge) begin
      ctrl_d[mcuic_pkg::EPF_BIT] = 1'b1;
    end
    if (tmr_ovf) begin
      ctrl_d[mcuic_pkg::TOF_BIT] = 1'b1;
    end
    if (pb_chg) begin
      ctrl_d[mcuic_pkg::PCF_BIT] = 1'b1;
    end
    pflg_d = pflg_d | (pev & mcuic_pkg::PERIPH_IMPL);
    // Status read clears; new event in same cycle still lands
    if (rd_hit(bus, mcuic_pkg::EVT_STAT_ADDR)) begin
      evst_d = 3'h0;
    end
    if (core.take) begin
      evst_d[mcuic_pkg::EV_VECTOR] = 1'b1;
    end
    if (wake_d && !wake_q) begin
      evst_d[mcuic_pkg::EV_WAKE] = 1'b1;
    end
    if (pin_edge) begin
      evst_d[mcuic_pkg::EV_PIN] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= mcuic_pkg::CORE_CTRL_RST;
      pflg_q <= mcuic_pkg::PERIPH_RST;
      pena_q <= mcuic_pkg::PERIPH_RST;
      opt_q  <= mcuic_pkg::OPTION_RST;
      evst_q <= 3'h0;
      evmk_q <= 3'h0;
    end else begin
      ctrl_q <= ctrl_d;
      pflg_q <= pflg_d;
      pena_q <= pena_d;
      opt_q  <= opt_d;
      evst_q <= evst_d;
      evmk_q <= evmk_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request, wake, vector and read-back
  always_comb begin
    pend_core = (ctrl_q[mcuic_pkg::TOE_BIT] && ctrl_q[mcuic_pkg::TOF_BIT]) ||
                (ctrl_q[mcuic_pkg::EPE_BIT] && ctrl_q[mcuic_pkg::EPF_BIT]) ||
                (ctrl_q[mcuic_pkg::PCE_BIT] && ctrl_q[mcuic_pkg::PCF_BIT]);
    pend_per  = ctrl_q[mcuic_pkg::PGE_BIT] && |(pflg_q & pena_q);
    pend_any  = pend_core || pend_per;
    req_d  = ctrl_q[mcuic_pkg::GEN_BIT] && pend_any && !core.take;
    wake_d = in_sleep && pend_any;
    vld_d  = core.take;
    push_d = core.take;
    vpc_d  = core.take ? mcuic_pkg::VECTOR_ADDR : vpc_q;
    padr_d = core.take ? core.ret_addr : padr_q;
    irq_d  = |(evst_d & evmk_q);
    rdata_d = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        mcuic_pkg::CORE_CTRL_ADDR:  rdata_d = ctrl_q;
        mcuic_pkg::PERIPH_FLG_ADDR: rdata_d = pflg_q;
        mcuic_pkg::PERIPH_ENA_ADDR: rdata_d = pena_q;
        mcuic_pkg::OPTION_ADDR:     rdata_d = opt_q;
        mcuic_pkg::EVT_STAT_ADDR:   rdata_d = {5'h00, evst_q};
        mcuic_pkg::EVT_MASK_ADDR:   rdata_d = {5'h00, evmk_q};
        default:                    rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_q   <= 1'b0;
      wake_q  <= 1'b0;
      vld_q   <= 1'b0;
      push_q  <= 1'b0;
      vpc_q   <= 13'h0000;
      padr_q  <= 13'h0000;
      irq_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      req_q   <= req_d;
      wake_q  <= wake_d;
      vld_q   <= vld_d;
      push_q  <= push_d;
      vpc_q   <= vpc_d;
      padr_q  <= padr_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign irq_request = req_q;
  assign wake_up     = wake_q;
  assign vector_load = vld_q;
  assign vector_pc   = vpc_q;
  assign push_valid  = push_q;
  assign push_addr   = padr_q;
  assign irq_out     = irq_q;
  assign rdata       = rdata_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_gen_reset;
    @(posedge clock) $rose(arst_n) |-> !ctrl_q[mcuic_pkg::GEN_BIT];
  endproperty
  a_gen_reset: assert property (p_gen_reset) else $error("enable not clear");

  property p_req_needs_gen;
    @(posedge clock) disable iff (!arst_n)
      irq_request |-> $past(ctrl_q[mcuic_pkg::GEN_BIT]);
  endproperty
  a_req_needs_gen: assert property (p_req_needs_gen) else $error("req w/o enable");

  property p_req_prompt;
    @(posedge clock) disable iff (!arst_n)
      (ctrl_q[mcuic_pkg::GEN_BIT] && pend_any && !core.take) |=> irq_request;
  endproperty
  a_req_prompt: assert property (p_req_prompt) else $error("req late");

  property p_take_clears;
    @(posedge clock) disable iff (!arst_n)
      core.take |=> !ctrl_q[mcuic_pkg::GEN_BIT] && vector_load &&
                    vector_pc == mcuic_pkg::VECTOR_ADDR;
  endproperty
  a_take_clears: assert property (p_take_clears) else $error("bad service");

  property p_ret_sets;
    @(posedge clock) disable iff (!arst_n)
      (return_from_handler && !core.take) |=> ctrl_q[mcuic_pkg::GEN_BIT];
  endproperty
  a_ret_sets: assert property (p_ret_sets) else $error("enable not set");

  property p_pin_latency;
    @(posedge clock) disable iff (!arst_n)
      $rose(pin_sync_q[1]) && opt_q[mcuic_pkg::EDGE_SEL_BIT]
      |-> ##[1:2] ctrl_q[mcuic_pkg::EPF_BIT];
  endproperty
  a_pin_latency: assert property (p_pin_latency) else $error("pin flag late");

  property p_tmr_flag;
    @(posedge clock) disable iff (!arst_n)
      tmr_ovf |=> ctrl_q[mcuic_pkg::TOF_BIT];
  endproperty
  a_tmr_flag: assert property (p_tmr_flag) else $error("ovf lost");

  property p_wake;
    @(posedge clock) disable iff (!arst_n)
      (in_sleep && pend_any) |=> wake_up;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_set_wins;
    @(posedge clock) disable iff (!arst_n)
      (pb_chg && wr_hit(bus, mcuic_pkg::CORE_CTRL_ADDR))
      |=> ctrl_q[mcuic_pkg::PCF_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost");
endmodule

// ===== rtl/mcuic_pkg.sv
// Purpose: Constants and carriers for the interrupt collection block
// Assumes: 8-bit register port, one instruction clock
// Notes:   Bit positions follow the core control, option and event status register layouts
package mcuic_pkg;
  localparam logic [7:0] CORE_CTRL_ADDR  = 8'h0b;
  localparam logic [7:0] PERIPH_FLG_ADDR = 8'h0c;
  localparam logic [7:0] PERIPH_ENA_ADDR = 8'h8c;
  localparam logic [7:0] OPTION_ADDR     = 8'h81;
  localparam logic [7:0] EVT_STAT_ADDR   = 8'hf0;
  localparam logic [7:0] EVT_MASK_ADDR   = 8'hf1;
  // Core control bit positions, then EDGE_SEL_BIT in the option register
  localparam int GEN_BIT  = 7;
  localparam int PGE_BIT  = 6;
  localparam int TOE_BIT  = 5;
  localparam int EPE_BIT  = 4;
  localparam int PCE_BIT  = 3;
  localparam int TOF_BIT  = 2;
  localparam int EPF_BIT  = 1;
  localparam int PCF_BIT  = 0;
  localparam int EDGE_SEL_BIT = 6;
  localparam logic [7:0] CORE_CTRL_RST  = 8'h00;
  localparam logic [7:0] PERIPH_RST     = 8'h00;
  localparam logic [7:0] OPTION_RST     = 8'hff;
  localparam logic [7:0] PERIPH_IMPL    = 8'h7f;
  localparam logic [12:0] VECTOR_ADDR   = 13'h0004;
  localparam logic [7:0] TIMER_MAX      = 8'hff;
  // Event status bits
  localparam int EV_VECTOR = 0;
  localparam int EV_WAKE   = 1;
  localparam int EV_PIN    = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcuic_bus_s;

  typedef struct packed {
    logic        take;
    logic [12:0] ret_addr;
  } mcuic_core_s;
endpackage

// ===== testbench/mcuic_core_model.sv
// Purpose: Behavioural core that services interrupt requests
// Assumes: Request sampled on rising edges, answer after dly cycles
// Notes:   Return address is driven to its inverse after each take, and is zero before the first
`timescale 1ns/1ns
module mcuic_core_model (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Bench control
  input  wire logic              en,
  input  wire logic [3:0]        dly,
  input  wire logic [12:0]       ret,
  // Block side
  input  wire logic              irq_request,
  output mcuic_pkg::mcuic_core_s core
);
  initial core = '0;
  always begin
    @(posedge clock);
    if (arst_n && en && irq_request) begin
      repeat (dly) @(posedge clock);
      core <= '{take: 1'b1, ret_addr: ret};
      @(posedge clock);
      // Stale address must not look valid
      core <= '{take: 1'b0, ret_addr: ~ret};
      repeat (2) @(posedge clock);
    end
  end
endmodule

// ===== testbench/test_mcuic_top.sv
// Purpose: Self-checking bench for the interrupt collection block
// Assumes: Core model services requests; bench plays software
// Notes:   Pin paths carry a two-flop synchroniser delay
`timescale 1ns/1ns
module test_mcuic_top;
  localparam logic [12:0] RET = 13'h0abc;
  logic                   clock = 1'b0;
  logic                   arst_n;
  mcuic_pkg::mcuic_bus_s  bus;
  mcuic_pkg::mcuic_core_s core;
  logic [7:0]             rdata, tmr, pev;
  logic [3:0]             pb;
  logic                   pin, rfh, slp, cen;
  logic                   irq, wake, vld, pshv, iout;
  logic [12:0]            vpc, padr;
  int                     n_fail = 0;
  int                     comparisons = 0;
  int                     n;
  mcuic_top #(.PERIPH_W(8)) uut (
    .clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .external_irq_pin(pin), .port_b_pins(pb),
    .eight_bit_timer(tmr), .periph_events(pev), .core(core),
    .return_from_handler(rfh), .in_sleep(slp),
    .irq_request(irq), .wake_up(wake), .vector_load(vld),
    .vector_pc(vpc), .push_valid(pshv), .push_addr(padr),
    .irq_out(iout)
  );
  mcuic_core_model cm (
    .clock(clock), .arst_n(arst_n), .en(cen), .dly(4'h2),
    .ret(RET), .irq_request(irq), .core(core)
  );
  always #4 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cb(input logic got, input logic exp);
    chk({12'h000, got}, {12'h000, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    #1;
    chk({5'h00, rdata}, {5'h00, e});
  endtask
  task automatic wt(input int s);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge clock);
      #1;
      n++;
      hit = (s == 0) ? (irq === 1'b1) :
            (s == 1) ? (wake === 1'b1) : (vld === 1'b1);
      if (!hit && n > 20) begin
        n_fail++;
        $display("[ERR] %0t wait timed out", $time);
        test_done();
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(8'h0b, 8'h00);
    rc(8'h0c, 8'h00);
    rc(8'h8c, 8'h00);
    rc(8'h81, 8'hff);
    rc(8'h55, 8'h00);
  endtask
  task automatic t_vector();
    cen = 1'b1;
    wr(8'h0b, 8'h90);
    @(posedge clock);
    pin <= 1'b1;
    wt(0);
    cb(n >= 3 && n <= 5, 1'b1);
    wt(2);
    cen = 1'b0;
    chk(vpc, 13'h0004);
    chk(padr, RET);
    cb(pshv, 1'b1);
    rc(8'h0b, 8'h12);
    wr(8'h0b, 8'h10);
    @(posedge clock);
    rfh <= 1'b1;
    @(posedge clock);
    rfh <= 1'b0;
    rc(8'h0b, 8'h90);
    cb(irq, 1'b0);
  endtask
  task automatic t_edge();
    wr(8'h0b, 8'h00);
    wr(8'h81, 8'hbf);
    @(posedge clock);
    pin <= 1'b0;
    repeat (6) @(posedge clock);
    rc(8'h0b, 8'h02);
    wr(8'h0b, 8'h00);
    @(posedge clock);
    pin <= 1'b1;
    repeat (6) @(posedge clock);
    rc(8'h0b, 8'h00);
    wr(8'h81, 8'hff);
  endtask
  task automatic t_masked();
    @(posedge clock);
    tmr <= 8'hff;
    pb <= 4'h5;
    @(posedge clock);
    tmr <= 8'h00;
    repeat (6) @(posedge clock);
    rc(8'h0b, 8'h05);
    cb(irq, 1'b0);
    wr(8'h0b, 8'ha5);
    wt(0);
    wr(8'h0b, 8'h00);
  endtask
  task automatic t_periph();
    wr(8'h8c, 8'h01);
    wr(8'h0b, 8'h80);
    @(posedge clock);
    pev <= 8'hff;
    @(posedge clock);
    pev <= 8'h00;
    repeat (2) @(posedge clock);
    rc(8'h0c, 8'h7f);
    cb(irq, 1'b0);
    wr(8'h0b, 8'hc0);
    wt(0);
    wr(8'h0b, 8'h00);
    wr(8'h0c, 8'h00);
    rc(8'h0c, 8'h00);
  endtask
  task automatic t_wake();
    @(posedge clock);
    slp <= 1'b1;
    pin <= 1'b0;
    wr(8'h0b, 8'h10);
    @(posedge clock);
    pin <= 1'b1;
    wt(1);
    cb(irq, 1'b0);
    @(posedge clock);
    slp <= 1'b0;
    pin <= 1'b0;
    wr(8'h0b, 8'h00);
  endtask
  task automatic t_events();
    rc(8'hf0, 8'h07);
    rc(8'hf0, 8'h00);
    wr(8'hf1, 8'h04);
    rc(8'hf1, 8'h04);
    @(posedge clock);
    pin <= 1'b1;
    repeat (7) @(posedge clock);
    #1;
    cb(iout, 1'b1);
    wr(8'hf1, 8'h00);
    repeat (3) @(posedge clock);
    #1;
    cb(iout, 1'b0);
    rc(8'hf0, 8'h04);
    wr(8'hf1, 8'h04);
    repeat (3) @(posedge clock);
    #1;
    cb(iout, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    bus = '0;
    pin = 1'b0;
    pb = 4'h0;
    tmr = 8'h00;
    pev = 8'h00;
    rfh = 1'b0;
    slp = 1'b0;
    cen = 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_vector();
    t_edge();
    t_masked();
    t_periph();
    t_wake();
    t_events();
    test_done();
  end
endmodule
